// [rtl/bmd_decode.sv]
// Purpose: on-board memory map decode, bus cycle timing and clock routing
// Assumes: processor address strobe marks the first state of a cycle
// Notes:   jumpers are read as plain synchronous levels
//
// How it works
// (RL1) base ram answers 0 through 1fff
// (RL2) ram expansion widens ram to 3fff
// (RL3) rom window base set by device size jumper
// (RL4) rom expansion doubles window, down to e0000
// (RL5) timer counter output drives request line two
// (RL6) all interrupts via controller except non-maskable
// (RL7) byte and word memory accesses supported
// (RL8) bus cycle lasts at least four states
// (RL9) rom cycles add zero to three waits
// (RL10) twenty bit address, unmapped goes off-board
// (RL11) io address driven eight or sixteen wide
// (RL12) bus interrupts non-vectored, level or edge
// (RL13) sixteen bit board works with byte module
// (RL14) timer and serial clocks at fixed rates
// (RL15) serial bit clock from a timer output
// (RL16) cpu rate 8 MHz, or 5 MHz jumpered
// (RL17) unmatched address selects no on-board memory
`timescale 1ns/1ps
module bmd_decode (
  // clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rstn_in,
  // board jumpers
  input  wire bmd_pkg::bmd_jumper_t  jumper_in,
  // processor local bus
  input  wire logic [19:0]           cpu_addr_in,
  input  wire logic                  cpu_ale_in,     // cycle start strobe
  input  wire logic                  cpu_mem_in,     // memory, not io
  input  wire logic                  cpu_bhen_in,    // high byte, low true
  input  wire logic                  cpu_io16_in,    // wide io address
  output logic                       cpu_ready_out,  // cycle may end
  output logic                       cpu_clk_en_out, // processor state tick
  // decoded selects
  output bmd_pkg::bmd_sel_t          sel_out,
  output logic [15:0]                io_addr_out,
  // expansion module
  output logic                       sbx_hi_lane_out, // use high data lane
  // interrupt routing
  input  wire logic [bmd_pkg::IRQ_W-1:0] bus_irq_n_in, // system bus requests
  input  wire logic                  edge_mode_in,   // edge sensed requests
  input  wire logic [2:0]            timer_out_in,   // counter outputs
  input  wire logic                  nmi_src_in,
  output logic [bmd_pkg::IRQ_W-1:0]  pic_ir_out,     // controller requests
  output logic                       nmi_out,        // straight to cpu
  // timer and serial clocks
  output logic [2:0]                 timer_clk_en_out,
  output logic                       serial_clk_en_out,
  output logic                       serial_baud_out
);
  // ---- window decode, used for both ram and rom tests ----
  function automatic logic in_window(input logic [19:0] a,
                                     input logic [19:0] lo,
                                     input logic [19:0] hi);
    in_window = (a >= lo) && (a <= hi);
  endfunction : in_window

  // ram last address from expansion jumper
  wire [19:0] ram_top = jumper_in.ram_exp ? bmd_pkg::RAM_TOP_EXP  // RL2
                                          : bmd_pkg::RAM_TOP_BASE; // RL1
  // rom base by device size; expansion steps one size down the table
  logic [19:0] rom_base_plain;
  logic [19:0] rom_base_exp;
  always_comb begin
    case (jumper_in.rom_size) // RL3
      bmd_pkg::BMD_ROM_2K:  rom_base_plain = bmd_pkg::ROM_BASE_2K;
      bmd_pkg::BMD_ROM_4K:  rom_base_plain = bmd_pkg::ROM_BASE_4K;
      bmd_pkg::BMD_ROM_8K:  rom_base_plain = bmd_pkg::ROM_BASE_8K;
      bmd_pkg::BMD_ROM_16K: rom_base_plain = bmd_pkg::ROM_BASE_16K;
      default:              rom_base_plain = bmd_pkg::ROM_BASE_2K;
    endcase
  end
  always_comb begin
    case (jumper_in.rom_size) // RL4
      bmd_pkg::BMD_ROM_2K:  rom_base_exp = bmd_pkg::ROM_BASE_4K;
      bmd_pkg::BMD_ROM_4K:  rom_base_exp = bmd_pkg::ROM_BASE_8K;
      bmd_pkg::BMD_ROM_8K:  rom_base_exp = bmd_pkg::ROM_BASE_16K;
      bmd_pkg::BMD_ROM_16K: rom_base_exp = bmd_pkg::ROM_BASE_EXP16;
      default:              rom_base_exp = bmd_pkg::ROM_BASE_4K;
    endcase
  end
  wire [19:0] rom_base = jumper_in.rom_exp ? rom_base_exp : rom_base_plain;

  // combinational hits on the live address
  wire hit_ram = cpu_mem_in &&
                 in_window(cpu_addr_in, 20'h00000, ram_top);
  wire hit_rom = cpu_mem_in &&
                 in_window(cpu_addr_in, rom_base, bmd_pkg::ROM_TOP);
  // anything else goes to the system bus, never both
  wire hit_bus = cpu_mem_in && !hit_ram && !hit_rom; // RL17 RL10
  // byte lanes: a0 low selects low byte, bhe low selects high byte
  wire lane_lo = !cpu_addr_in[0];  // RL7
  wire lane_hi = !cpu_bhen_in;     // RL7

  // ---- processor state rate ----
  logic cpu_tick;
  wire [bmd_pkg::DIV_W-1:0] cpu_ratio = jumper_in.cpu_slow
    ? bmd_pkg::DIV_W'(bmd_pkg::DIV_CPU_SLOW)   // RL16
    : bmd_pkg::DIV_W'(bmd_pkg::DIV_CPU_FAST);  // RL16
  bmd_clk_div u_cpu_div (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .ratio_in   (cpu_ratio),
    .tick_out   (cpu_tick)
  );
  assign cpu_clk_en_out = cpu_tick;

  // ---- bus cycle sequencer, counted in processor states ----
  typedef enum logic [1:0] { BMD_IDLE, BMD_RUN, BMD_WAIT } bmd_state_t;
  bmd_state_t  state;
  bmd_state_t  next_state;
  logic [2:0]  states_left;   // base states still to run
  logic [2:0]  next_states_left;
  logic [1:0]  waits_left;    // rom wait states still to run
  logic [1:0]  next_waits_left;
  bmd_pkg::bmd_sel_t next_sel;
  wire         start = cpu_ale_in && cpu_tick;

  // next state and counters
  always_comb begin
    next_state       = state;
    next_states_left = states_left;
    next_waits_left  = waits_left;
    case (state)
      BMD_IDLE: begin
        if (start) begin
          next_state       = BMD_RUN;
          next_states_left = bmd_pkg::BUS_STATES - 3'h1; // RL8
          // rom cycles take the jumpered wait count
          next_waits_left  = hit_rom ? jumper_in.rom_wait : 2'h0; // RL9
        end
      end
      BMD_RUN: begin
        if (cpu_tick) begin
          if (states_left > 3'h1) begin
            next_states_left = states_left - 3'h1;
          end else if (waits_left != 2'h0) begin
            next_state = BMD_WAIT; // RL9
          end else begin
            next_state = BMD_IDLE; // RL8
          end
        end
      end
      BMD_WAIT: begin
        if (cpu_tick) begin
          if (waits_left > 2'h1) begin
            next_waits_left = waits_left - 2'h1;
          end else begin
            next_waits_left = 2'h0;
            next_state      = BMD_IDLE;
          end
        end
      end
      default: next_state = BMD_IDLE;
    endcase
  end

  // selects are latched at the start of a cycle and held to its end
  always_comb begin
    next_sel = sel_out;
    if (state == BMD_IDLE) begin
      if (start) begin
        next_sel = '{ram_sel: hit_ram, rom_sel: hit_rom, bus_sel: hit_bus,
                     lo_byte: lane_lo, hi_byte: lane_hi};
      end else begin
        next_sel = '0;
      end
    end
  end

  // sequencer registers
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state       <= BMD_IDLE;
      states_left <= 3'h0;
      waits_left  <= 2'h0;
      sel_out     <= '0;
    end else begin
      state       <= next_state;
      states_left <= next_states_left;
      waits_left  <= next_waits_left;
      sel_out     <= next_sel;
    end
  end

  // ready holds low until the last base state, or until the last wait state of a rom cycle with waits
  assign cpu_ready_out = (state == BMD_IDLE) ||
                         (state == BMD_RUN && states_left <= 3'h1 &&
                          waits_left == 2'h0) ||
                         (state == BMD_WAIT && waits_left <= 2'h1);

  // ---- io address, latched on the strobe ----
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      io_addr_out <= 16'h0000;
    end else if (start && !cpu_mem_in && state == BMD_IDLE) begin
      // short io addresses carry zero in the upper byte
      io_addr_out <= cpu_io16_in ? cpu_addr_in[15:0] // RL11
                                 : {8'h00, cpu_addr_in[7:0]}; // RL11
    end
  end

  // byte-wide module: odd bytes steered down onto the low lane
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sbx_hi_lane_out <= 1'b0;
    end else begin
      sbx_hi_lane_out <= !jumper_in.sbx_8bit && !cpu_bhen_in; // RL13
    end
  end

  // ---- interrupt routing ----
  // edge mode turns each bus request into a one-cycle pulse; level
  // mode passes it through. bus requests carry no vector. // RL12
  logic [bmd_pkg::IRQ_W-1:0] irq_prev;
  wire  [bmd_pkg::IRQ_W-1:0] irq_lvl  = ~bus_irq_n_in;
  wire  [bmd_pkg::IRQ_W-1:0] irq_rise = irq_lvl & ~irq_prev;
  wire  [bmd_pkg::IRQ_W-1:0] irq_bus  = edge_mode_in ? irq_rise
                                                     : irq_lvl; // RL12
  wire  [bmd_pkg::IRQ_W-1:0] irq_tmr  =
    bmd_pkg::IRQ_W'(timer_out_in[0]) << bmd_pkg::IRQ_TIMER_LINE; // RL5
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_prev   <= '0;
      pic_ir_out <= '0;
      nmi_out    <= 1'b0;
    end else begin
      irq_prev   <= irq_lvl;
      pic_ir_out <= irq_bus | irq_tmr; // RL6
      nmi_out    <= nmi_src_in;        // RL6
    end
  end

  // ---- timer and serial clock enables ----
  logic tick_fast;
  logic tick_slow;
  bmd_clk_div u_fast_div (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .ratio_in   (bmd_pkg::DIV_W'(bmd_pkg::DIV_TMR_FAST)),
    .tick_out   (tick_fast)
  );
  bmd_clk_div u_slow_div (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .ratio_in   (bmd_pkg::DIV_W'(bmd_pkg::DIV_TMR_SLOW)),
    .tick_out   (tick_slow)
  );
  assign timer_clk_en_out  = {tick_fast, tick_slow, tick_fast}; // RL14
  assign serial_clk_en_out = tick_fast;                          // RL14
  // baud clock follows timer counter two output
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_baud_out <= 1'b0;
    end else begin
      serial_baud_out <= timer_out_in[2]; // RL15
    end
  end
endmodule : bmd_decode

// [rtl/bmd_pkg.sv]
// Purpose: shared constants and types for the board memory map decoder
// Assumes: 25 MHz system clock, 20-bit processor address
// Notes:   figures are named once here and used by name in the rtl, bar ADDR_W and ROM_WAIT_MAX; the checker and bench repeat them as literals
package bmd_pkg;
  // clock and derived rates
  localparam int unsigned CLK_SYS_HZ     = 25000000;  // system clock rate
  localparam int unsigned TMR_FAST_HZ    = 1229000;   // timer 0/2, serial
  localparam int unsigned TMR_SLOW_HZ    = 153600;    // timer 1
  localparam int unsigned CPU_FAST_HZ    = 8000000;   // default cpu rate
  localparam int unsigned CPU_SLOW_HZ    = 5000000;   // jumpered cpu rate
  // divider terms, computed as rounded quotients of the system rate
  localparam int unsigned DIV_TMR_FAST =
    (CLK_SYS_HZ + TMR_FAST_HZ / 2) / TMR_FAST_HZ;
  localparam int unsigned DIV_TMR_SLOW =
    (CLK_SYS_HZ + TMR_SLOW_HZ / 2) / TMR_SLOW_HZ;
  localparam int unsigned DIV_CPU_FAST =
    (CLK_SYS_HZ + CPU_FAST_HZ / 2) / CPU_FAST_HZ;
  localparam int unsigned DIV_CPU_SLOW =
    (CLK_SYS_HZ + CPU_SLOW_HZ / 2) / CPU_SLOW_HZ;
  localparam int unsigned DIV_W        = 8;         // divider count width
  // bus cycle timing
  localparam int unsigned SINGLE_CYCLE_NS = 125;    // one processor state
  localparam int unsigned BUS_CYCLE_NS    = 500;    // least bus cycle
  localparam logic [2:0]  BUS_STATES      = 3'(BUS_CYCLE_NS / SINGLE_CYCLE_NS);
  localparam logic [1:0]  ROM_WAIT_MAX    = 2'h3;   // most rom wait states
  // address map
  localparam int unsigned ADDR_W        = 20;
  localparam logic [19:0] RAM_TOP_BASE  = 20'h01fff; // base ram last byte
  localparam logic [19:0] RAM_TOP_EXP   = 20'h03fff; // expanded ram last
  localparam logic [19:0] ROM_TOP       = 20'hfffff; // rom window end
  localparam logic [19:0] ROM_BASE_2K   = 20'hfe000;
  localparam logic [19:0] ROM_BASE_4K   = 20'hfc000;
  localparam logic [19:0] ROM_BASE_8K   = 20'hf8000;
  localparam logic [19:0] ROM_BASE_16K  = 20'hf0000;
  localparam logic [19:0] ROM_BASE_EXP16 = 20'he0000; // 16k with expansion
  // interrupt controller request lines
  localparam int unsigned IRQ_W          = 8;
  localparam int unsigned IRQ_TIMER_LINE = 2;  // interval timer request
  // rom device size jumper
  typedef enum logic [1:0] {
    BMD_ROM_2K, BMD_ROM_4K, BMD_ROM_8K, BMD_ROM_16K
  } bmd_rom_size_t;
  // board jumpers and fitted options
  typedef struct packed {
    bmd_rom_size_t rom_size;     // installed rom device size
    logic          ram_exp;      // ram expansion fitted
    logic          rom_exp;      // rom expansion fitted
    logic [1:0]    rom_wait;     // rom wait states 0..3
    logic          cpu_slow;     // run cpu at the slower rate
    logic          sbx_8bit;     // expansion module is byte wide
  } bmd_jumper_t;
  // decoded memory selects
  typedef struct packed {
    logic ram_sel;
    logic rom_sel;
    logic bus_sel;               // off-board system bus cycle
    logic lo_byte;               // low byte lane enabled
    logic hi_byte;               // high byte lane enabled
  } bmd_sel_t;
endpackage : bmd_pkg

// [rtl/bmd_clk_div.sv]
// Purpose: one-cycle enable pulse every ratio clocks
// Assumes: ratio of at least one, held steady apart from jumper changes
// Notes:   used for the timer, serial and cpu rate enables
`timescale 1ns/1ps
module bmd_clk_div (
  // clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rstn_in,
  // ratio and pulse
  input  wire logic [bmd_pkg::DIV_W-1:0] ratio_in,
  output logic                           tick_out
);
  logic [bmd_pkg::DIV_W-1:0] count;       // clocks since last pulse
  wire                       wrap = (count >= ratio_in - 8'h01);
  // counter wraps at ratio, pulse on the wrap cycle
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= '0;
    end else if (wrap) begin
      count <= '0;
    end else begin
      count <= count + 8'h01;
    end
  end
  assign tick_out = wrap;
endmodule : bmd_clk_div

// [sim/bmd_cpu_model.sv]
// Purpose: processor local bus model driving memory and io cycles
// Assumes: changes at falling edge, start held until a taken tick
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ps
module bmd_cpu_model (
  // clock and handshake from the decoder
  input  wire logic clk_sys_in, cpu_clk_en_in, cpu_ready_in,
  // driven bus lines
  output logic [19:0] addr_out,
  output logic        ale_out, mem_out, bhen_out, io16_out
);
  initial begin
    addr_out = 20'h00000;
    {ale_out, mem_out, bhen_out, io16_out} = 4'h6;
  end
  // one whole cycle; ok low when the decoder never answered
  task automatic run(input logic [19:0] a, input logic m, b, w,
                     output logic ok);
    int n;
    logic low;
    n = 0;
    low = 1'b0;
    ok = 1'b1;
    @(negedge clk_sys_in);
    addr_out = a;
    mem_out = m;
    bhen_out = b;
    io16_out = w;
    ale_out = 1'b1;
    // start stays up until a state tick samples it
    do begin @(posedge clk_sys_in); n++; end
    while (!cpu_clk_en_in && n < 100);
    if (!cpu_clk_en_in) ok = 1'b0;
    @(negedge clk_sys_in);
    ale_out = 1'b0;
    // invert, so a stale copy cannot pass for a live one
    {addr_out, mem_out, bhen_out, io16_out} = ~{a, m, b, w};
    do begin @(posedge clk_sys_in); n++; low |= !cpu_ready_in; end
    while (!(low && cpu_ready_in && cpu_clk_en_in) && n < 300);
    if (!(low && cpu_ready_in && cpu_clk_en_in)) ok = 1'b0;
  endtask : run
endmodule : bmd_cpu_model

// [sim/bmd_decode_checker.sv]
// Purpose: temporal checks on the decoder's ports
// Assumes: jumpers change only while reset is held
// Notes:   cycle length is bounded loosely, ready being combinational
`timescale 1ns/1ps
module bmd_decode_checker (
  input wire logic clk_sys_in, rstn_in,
  input wire bmd_pkg::bmd_jumper_t jumper_in,
  input wire logic [19:0] cpu_addr_in,
  input wire logic cpu_ale_in, cpu_mem_in, cpu_bhen_in, cpu_io16_in,
  input wire logic cpu_ready_out, cpu_clk_en_out,
  input wire bmd_pkg::bmd_sel_t sel_out,
  input wire logic [15:0] io_addr_out,
  input wire logic [bmd_pkg::IRQ_W-1:0] pic_ir_out,
  input wire logic [2:0] timer_out_in, timer_clk_en_out,
  input wire logic nmi_src_in, nmi_out, serial_clk_en_out, serial_baud_out,
  input wire logic sbx_hi_lane_out, edge_mode_in,
  input wire logic [bmd_pkg::IRQ_W-1:0] bus_irq_n_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // idle means ready and no window selected
  wire take = cpu_ale_in && cpu_clk_en_out && cpu_ready_out &&
              !(sel_out.ram_sel || sel_out.rom_sel || sel_out.bus_sel);
  wire [2:0] idx = {1'b0, jumper_in.rom_size} + 3'(jumper_in.rom_exp);
  wire [19:0] top = jumper_in.ram_exp ? 20'h03fff : 20'h01fff;
  wire [19:0] base = idx == 3'h0 ? 20'hfe000 : idx == 3'h1 ? 20'hfc000 :
                     idx == 3'h2 ? 20'hf8000 : idx == 3'h3 ? 20'hf0000 :
                     20'he0000;
  logic [3:0] ticks;  // state ticks since the cycle was taken
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in) ticks <= 4'h0;
    else if (take) ticks <= 4'h0;
    else if (cpu_clk_en_out && ticks != 4'hf) ticks <= ticks + 4'h1;
  wire [3:0] w = sel_out.rom_sel ? {2'h0, jumper_in.rom_wait} : 4'h0;
  sequence s_mem; take && cpu_mem_in; endsequence
  a_ram_window: assert property (s_mem ##0 cpu_addr_in <= top |=>
    sel_out.ram_sel && !sel_out.rom_sel) else $error("ram not selected");
  a_rom_window: assert property (s_mem ##0 cpu_addr_in >= base |=>
    sel_out.rom_sel && !sel_out.ram_sel) else $error("rom not selected");
  a_off_board: assert property (s_mem ##0 cpu_addr_in > top &&
    cpu_addr_in < base |=> sel_out.bus_sel && !sel_out.ram_sel &&
    !sel_out.rom_sel) else $error("unmapped address selected on board");
  a_byte_lanes: assert property (s_mem |=>
    sel_out.lo_byte == !$past(cpu_addr_in[0]) &&
    sel_out.hi_byte == !$past(cpu_bhen_in)) else $error("lane mismatch");
  a_io_latch: assert property (take && !cpu_mem_in && cpu_io16_in |=>
    io_addr_out == $past(cpu_addr_in[15:0])) else $error("io address");
  a_cycle_len: assert property ($rose(cpu_ready_out) |->
    ticks >= 4'h2 + w && ticks <= 4'h4 + w) else $error("cycle length");
  a_timer_irq: assert property (timer_out_in[0] |=> pic_ir_out[2])
    else $error("timer request not routed");
  a_nmi_bypass: assert property ($past(rstn_in) |->
    nmi_out == $past(nmi_src_in)) else $error("nmi not passed");
  a_fast_rate: assert property (timer_clk_en_out[0] |->
    serial_clk_en_out ##20 timer_clk_en_out[0]) else $error("fast rate");
  a_slow_rate: assert property (timer_clk_en_out[1] |->
    ##163 timer_clk_en_out[1]) else $error("slow timer rate");
  a_cpu_rate: assert property (cpu_clk_en_out && !jumper_in.cpu_slow |=>
    !cpu_clk_en_out ##1 !cpu_clk_en_out ##1 cpu_clk_en_out)
    else $error("cpu state rate");
  a_baud_src: assert property ($past(rstn_in) |->
    serial_baud_out == $past(timer_out_in[2])) else $error("baud source");
  a_byte_module: assert property ($past(rstn_in) |->
    sbx_hi_lane_out == (!$past(jumper_in.sbx_8bit) && !$past(cpu_bhen_in)))
    else $error("byte module lane");
  a_edge_pulse: assert property (edge_mode_in && pic_ir_out[3] |=>
    !pic_ir_out[3]) else $error("edge request held");
  a_level_pass: assert property (!edge_mode_in && !bus_irq_n_in[0] |=>
    pic_ir_out[0]) else $error("level request not passed");
endmodule : bmd_decode_checker
bind bmd_decode bmd_decode_checker i_chk (.clk_sys_in, .rstn_in, .jumper_in,
  .cpu_addr_in, .cpu_ale_in, .cpu_mem_in, .cpu_bhen_in, .cpu_io16_in,
  .cpu_ready_out, .cpu_clk_en_out, .sel_out, .io_addr_out, .pic_ir_out,
  .timer_out_in, .timer_clk_en_out, .nmi_src_in, .nmi_out,
  .serial_clk_en_out, .serial_baud_out, .sbx_hi_lane_out, .edge_mode_in,
  .bus_irq_n_in);

// [sim/board_memory_map_decode_tb_top.sv]
// Purpose: self-checking bench for the memory map decoder
// Assumes: inputs change at the falling edge
// Notes:   window selects are scored through a queue by a watcher
`timescale 1ns/1ps
module board_memory_map_decode_tb_top;
  logic clk_sys_in, rstn_in, edge_m, nmi, ale, mem, bhen, io16, ok;
  logic rdy, clk_en, sbx_hi, nmi_o, sclk, baud;
  logic [19:0] addr;
  logic [15:0] io_a;
  logic [7:0] irq_n, pic;
  logic [2:0] tmr, tclk;
  bmd_pkg::bmd_jumper_t jmp;
  bmd_pkg::bmd_sel_t sel, exp_q[$];
  logic [2:0] prev_win;  // window bits seen at the last falling edge
  int n_fail, comparisons;
  logic [19:0] rom_base [5] = '{20'hfe000, 20'hfc000, 20'hf8000,
                                 20'hf0000, 20'he0000};
  wire [3:0] probe = {clk_en, tclk};
  bmd_decode i_dut (.clk_sys_in, .rstn_in, .jumper_in(jmp),
    .cpu_addr_in(addr), .cpu_ale_in(ale), .cpu_mem_in(mem),
    .cpu_bhen_in(bhen), .cpu_io16_in(io16), .cpu_ready_out(rdy),
    .cpu_clk_en_out(clk_en), .sel_out(sel), .io_addr_out(io_a),
    .sbx_hi_lane_out(sbx_hi), .bus_irq_n_in(irq_n), .edge_mode_in(edge_m),
    .timer_out_in(tmr), .nmi_src_in(nmi), .pic_ir_out(pic), .nmi_out(nmi_o),
    .timer_clk_en_out(tclk), .serial_clk_en_out(sclk),
    .serial_baud_out(baud));
  bmd_cpu_model i_cpu (.clk_sys_in, .cpu_clk_en_in(clk_en),
    .cpu_ready_in(rdy), .addr_out(addr), .ale_out(ale), .mem_out(mem),
    .bhen_out(bhen), .io16_out(io16));
  initial begin clk_sys_in = 1'b0; forever #20 clk_sys_in = ~clk_sys_in; end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [19:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic bmd_pkg::bmd_sel_t exp_sel(input logic [19:0] a,
                                                input logic b);
    bmd_pkg::bmd_sel_t e;
    e.ram_sel = a <= (jmp.ram_exp ? 20'h03fff : 20'h01fff);
    e.rom_sel = a >= rom_base[{1'b0, jmp.rom_size} + 3'(jmp.rom_exp)];
    e.bus_sel = !e.ram_sel && !e.rom_sel;
    e.lo_byte = !a[0];
    e.hi_byte = !b;
    return e;
  endfunction : exp_sel
  // jumpers are only moved while reset is held
  task automatic do_reset(input bmd_pkg::bmd_jumper_t j);
    @(negedge clk_sys_in);
    rstn_in = 1'b0;
    jmp = j;
    repeat (20) @(negedge clk_sys_in);
    rstn_in = 1'b1;
  endtask : do_reset
  task automatic access(input logic [19:0] a, input logic m, b, w);
    if (m) exp_q.push_back(exp_sel(a, b));
    i_cpu.run(a, m, b, w, ok);
    if (!ok) begin n_fail++; $display("MISMATCH at %0t: hang", $time); end
    if (!ok) print_verdict();
  endtask : access
  task automatic per(input int k, e);
    int n;
    n = 0;
    do begin @(posedge clk_sys_in); n++; end while (!probe[k] && n < 400);
    n = 0;
    do begin @(posedge clk_sys_in); n++; end while (!probe[k] && n < 400);
    chk(20'(n), 20'(e), "tick period");
  endtask : per
  // watcher: a new window select pops the oldest expectation
  always @(negedge clk_sys_in) begin
    if (rstn_in && prev_win === 3'h0 && sel.ram_sel | sel.rom_sel | sel.bus_sel)
      if (exp_q.size() == 0) chk(20'(sel), 20'h0, "unexpected select");
      else chk(20'(sel), 20'(exp_q.pop_front()), "select");
    prev_win <= {sel.ram_sel, sel.rom_sel, sel.bus_sel};
  end
  initial begin
    logic [19:0] b, lst [9];
    bmd_pkg::bmd_jumper_t j;  // next jumper set, applied only under reset
    {rstn_in, edge_m, nmi, tmr, irq_n} = {6'h0, 8'hff};
    jmp = '0;
    void'($urandom(32'h34780f47));
    repeat (20) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    for (int s = 0; s < 8; s++) for (int r = 0; r < 2; r++) begin
      j = bmd_pkg::bmd_jumper_t'(8'($urandom));
      j.rom_size = bmd_pkg::bmd_rom_size_t'(s[1:0]);
      {j.rom_exp, j.ram_exp} = {1'(s >> 2), 1'(r)};
      do_reset(j);
      b = rom_base[s[1:0] + (s >> 2)];
      lst = '{20'h00000, 20'h01fff, 20'h02000, 20'h03fff, 20'h04000,
              b - 20'h1, b, 20'hfffff, 20'($urandom)};
      foreach (lst[i]) access(lst[i], 1'b1, 1'($urandom), 1'b0);
    end
    $display("test memory map done");
    access(20'h0abcd, 1'b0, 1'b1, 1'b1);
    chk(20'(io_a), 20'h0abcd, "wide io address");
    chk(20'(sbx_hi), 20'(!jmp.sbx_8bit), "high lane, word module");
    access(20'h05ad4, 1'b0, 1'b0, 1'b0);
    chk(20'(io_a), 20'h000d4, "byte io address");
    chk(20'(sbx_hi), 20'h0, "high lane idle");
    $display("test io done");
    @(negedge clk_sys_in);
    {tmr, nmi, irq_n} = {3'h5, 1'b1, 8'hfe};
    repeat (2) @(negedge clk_sys_in);
    chk(20'({pic[2], pic[0], nmi_o, baud}), 20'hf, "requests set");
    {tmr, nmi, irq_n} = {3'h0, 1'b0, 8'hff};
    repeat (2) @(negedge clk_sys_in);
    chk(20'({pic, nmi_o, baud}), 20'h0, "requests clear");
    {edge_m, irq_n} = {1'b1, 8'hf7};
    @(negedge clk_sys_in);
    chk(20'(pic), 20'h8, "edge request pulse");
    @(negedge clk_sys_in);
    chk(20'(pic), 20'h0, "edge request over");
    {edge_m, irq_n} = {1'b0, 8'hff};
    $display("test interrupts done");
    j.cpu_slow = 1'b0;
    do_reset(j);
    per(3, 3);
    per(0, 20);
    per(1, 163);
    j.cpu_slow = 1'b1;
    do_reset(j);
    per(3, 5);
    $display("test rates done");
    chk(20'(exp_q.size()), 20'h0, "selects never seen");
    print_verdict();
  end
endmodule : board_memory_map_decode_tb_top
